// >>> rtl/psic_pkg.sv
// Purpose: constants for the phy status summary and interrupt control block
// Assumes: avalon-mm word addressing, 16-bit registers in the low half of a 32-bit word
// Notes: register indices are printed offsets; byte address is four times the index
// Functional notes
// - jabber summary bit 5 reports jabber only at 10 Mb/s.
// - summary jabber mirrors basic mode status jabber; summary read never clears it.
// - summary bit 4 shows auto-negotiation complete.
// - summary bit 3 shows loopback enabled.
// - summary bit 2 shows resolved duplex, 1 full, 0 half.
// - summary bit 1 shows resolved speed, 1 for 10, 0 for 100.
// - summary bit 0 mirrors link status; summary read never clears it.
// - interrupt control bits 15:3 ignore writes, read zero.
// - test interrupt force bit 2 raises an interrupt regardless of events.
// - forced interrupt holds while the bit stays set, stops when cleared.
// - global enable bit 1 gates all event interrupts.
// - bit 0 makes the shared pin an interrupt output, else power-down input.
// - sources: link quality, energy detect, link, speed, duplex, autoneg done, counters half full.
// - event status bits set on events even when not enabled.
// - reading event status clears pending bits and the pending interrupt.
// - summary bit 7 shows an internal interrupt pending.
package psic_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] IDX_SUMMARY = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_INT_CTRL = 8'h11;
    localparam logic [ADDR_W-1:0] IDX_EVENT = 8'h12;
    localparam int NUM_EVT = 8;
    // event bit positions in the event register upper byte
    localparam int EVT_LQ = 7;
    localparam int EVT_ED = 6;
    localparam int EVT_LINK = 5;
    localparam int EVT_SPD = 4;
    localparam int EVT_DUP = 3;
    localparam int EVT_ANC = 2;
    localparam int EVT_FHF = 1;
    localparam int EVT_RHF = 0;
    // summary field positions
    localparam int SUM_IRQ = 7;
    localparam int SUM_JAB = 5;
    localparam int SUM_ANC = 4;
    localparam int SUM_LPBK = 3;
    localparam int SUM_DUP = 2;
    localparam int SUM_SPD = 1;
    localparam int SUM_LINK = 0;
    // interrupt control fields
    localparam int CTL_TEST_INTERRUPT_FORCE = 2;
    localparam int CTL_GEN = 1;
    localparam int CTL_OE = 0;
    localparam logic [2:0] CTL_RESET = 3'h0;
    localparam logic [NUM_EVT-1:0] EVT_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        PSIC_IDLE = 2'b00,
        PSIC_DONE = 2'b01
    } psic_bus_e;
endpackage : psic_pkg

// >>> rtl/psic_evt_if.sv
// Purpose: carries event inputs, enables and pending state between main and latch module
// Assumes: single clock domain
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface psic_evt_if;
    import psic_pkg::*;
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EVT-1:0] en;
    logic clr;
    logic [NUM_EVT-1:0] pend;
    logic any_en;
    modport owner (output evt, output en, output clr, input pend, input any_en);
    modport latch (input evt, input en, input clr, output pend, output any_en);
endinterface : psic_evt_if
`default_nettype wire

// >>> rtl/psic_evt_latch.sv
// Purpose: sticky event status bits, cleared by a read of the event register
// Assumes: event inputs are one-cycle pulses synchronous to clk_i
// Notes: an event in the clearing cycle survives the clear
`timescale 1ns/100ps
`default_nettype none
module psic_evt_latch (
    input wire logic clk_i,
    input wire logic resetn_i,
    psic_evt_if.latch ev
);
    import psic_pkg::*;
    logic [NUM_EVT-1:0] pend_r;
    logic [NUM_EVT-1:0] pend_nxt;
    // set wins over clear-on-read
    assign pend_nxt = (ev.clr ? EVT_RESET : pend_r) | ev.evt;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_r <= EVT_RESET;
        end else begin
            pend_r <= pend_nxt;
        end
    end
    assign ev.pend = pend_r;
    assign ev.any_en = |(pend_r & ev.en);
    chk_evt_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ev.evt != EVT_RESET) |=> ((pend_r & $past(ev.evt)) == $past(ev.evt)))
        else $error("event not latched");
    chk_clear_on_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ev.clr && ev.evt == EVT_RESET) |=> pend_r == EVT_RESET)
        else $error("pending not cleared by read");
endmodule : psic_evt_latch
`default_nettype wire

// >>> rtl/psic_top.sv
// Purpose: phy status summary, interrupt control and event status registers on avalon-mm
// Assumes: status inputs are levels, event inputs one-cycle pulses, all synchronous to clk_i
// Notes: every access answers after one wait cycle; outputs come from flip-flops except avs_waitrequest_o, decoded from read, write and bus state
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module psic_top (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [psic_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic jabber_i,
    input wire logic autoneg_done_i,
    input wire logic loopback_i,
    input wire logic full_duplex_i,
    input wire logic speed_10_i,
    input wire logic link_up_i,
    input wire logic [psic_pkg::NUM_EVT-1:0] event_i,
    input wire logic powerdown_or_irq_pin_i,
    output logic powerdown_or_irq_pin_o,
    output logic powerdown_or_irq_pin_oen_o,
    output logic powerdown_req_o
);
    import psic_pkg::*;

    psic_evt_if ev ();
    psic_bus_e bus_r;
    psic_bus_e bus_nxt;
    logic [2:0] ctl_r;
    logic [NUM_EVT-1:0] en_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic oen_r;
    logic pd_r;

    // bus decode: each request waits one cycle, then completes
    wire req_w = (avs_read_i | avs_write_i) & (bus_r == PSIC_IDLE);
    wire hit_sum = avs_address_i == IDX_SUMMARY;
    wire hit_ctl = avs_address_i == IDX_INT_CTRL;
    wire hit_evt = avs_address_i == IDX_EVENT;
    wire wr_lo = avs_write_i & req_w & avs_byteenable_i[0];
    wire wr_ctl = wr_lo & hit_ctl;
    wire wr_evt = wr_lo & hit_evt;
    wire rd_evt = avs_read_i & req_w & hit_evt;
    assign bus_nxt = req_w ? PSIC_DONE : PSIC_IDLE;

    // status summary assembled from live inputs; reads never disturb them
    wire jab_10 = jabber_i & speed_10_i;
    wire irq_pend = ctl_r[CTL_TEST_INTERRUPT_FORCE] | (ev.pend != EVT_RESET);
    wire [15:0] sum_w = {8'h00, irq_pend, 1'b0, jab_10, autoneg_done_i,
        loopback_i, full_duplex_i, speed_10_i, link_up_i};
    wire [15:0] ctl_w = {13'h0000, ctl_r};
    wire [15:0] evt_w = {ev.pend, en_r};
    wire [31:0] rd_mux = hit_sum ? {16'h0000, sum_w} :
        hit_ctl ? {16'h0000, ctl_w} :
        hit_evt ? {16'h0000, evt_w} : UNMAPPED_DATA;

    // interrupt output, only while bit 0 enables the pin: test force, or global enable with any enabled pending event
    wire irq_nxt = ctl_r[CTL_OE] & (ctl_r[CTL_TEST_INTERRUPT_FORCE] | (ctl_r[CTL_GEN] & ev.any_en));

    assign ev.evt = event_i;
    assign ev.en = en_r;
    assign ev.clr = rd_evt;

    psic_evt_latch u_latch (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ev(ev)
    );

    // bus state and read data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_r <= PSIC_IDLE;
            rdata_r <= UNMAPPED_DATA;
        end else begin
            bus_r <= bus_nxt;
            if (avs_read_i & req_w) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // control and enable registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_r <= CTL_RESET;
            en_r <= EVT_RESET;
        end else begin
            if (wr_ctl) begin
                ctl_r <= avs_writedata_i[2:0];
            end
            if (wr_evt) begin
                en_r <= avs_writedata_i[NUM_EVT-1:0];
            end
        end
    end

    // shared pin: driven low-active irq when output enabled, else sampled power-down
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_r <= 1'b0;
            oen_r <= 1'b1;
            pd_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            oen_r <= ~ctl_r[CTL_OE];
            pd_r <= ~ctl_r[CTL_OE] & ~powerdown_or_irq_pin_i;
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (bus_r == PSIC_IDLE);
    assign avs_readdata_o = rdata_r;
    assign powerdown_or_irq_pin_o = ~irq_r;
    assign powerdown_or_irq_pin_oen_o = oen_r;
    assign powerdown_req_o = pd_r;

    chk_test_interrupt_force_forces: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ctl_r[CTL_TEST_INTERRUPT_FORCE] && ctl_r[CTL_OE]) |=> !powerdown_or_irq_pin_o)
        else $error("test force did not assert irq");
    chk_gen_gates: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!ctl_r[CTL_TEST_INTERRUPT_FORCE] && !ctl_r[CTL_GEN]) |=> powerdown_or_irq_pin_o)
        else $error("irq without enable");
    chk_pin_dir: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(ctl_r[CTL_OE]) |=> !powerdown_or_irq_pin_oen_o)
        else $error("pin not turned to output");
    chk_ctl_rsvd: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (bus_r == PSIC_DONE && $past(avs_read_i && hit_ctl)) |-> rdata_r[31:3] == 29'h0)
        else $error("reserved control bits nonzero");
    chk_jab_speed: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && req_w && hit_sum && !speed_10_i) |=> !rdata_r[SUM_JAB])
        else $error("jabber shown at 100");
    chk_link_mirror: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && req_w && hit_sum) |=> rdata_r[SUM_LINK] == $past(link_up_i))
        else $error("link bit mismatch");
    chk_sum_fields: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && req_w && hit_sum) |=> rdata_r[4:1] == $past({autoneg_done_i, loopback_i,
        full_duplex_i, speed_10_i}))
        else $error("summary fields mismatch");
    chk_pend_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && req_w && hit_sum && ev.pend != EVT_RESET) |=> rdata_r[SUM_IRQ])
        else $error("pending flag missing");
endmodule : psic_top
`default_nettype wire

// >>> testbench/psic_host_model.sv
// Purpose: host side of the shared power-down or interrupt pin
// Assumes: pin pulled high when nobody drives it
// Notes: host drives power-down only while the device leaves the pin as input
`timescale 1ns/100ps
`default_nettype none
module psic_host_model (
    input wire logic dev_pin_i,
    input wire logic dev_oen_i,
    input wire logic pd_n_i,
    output logic pin_lvl_o,
    output logic irq_seen_o
);
    // resolved wire level, fed back to the device pin input
    assign pin_lvl_o = !dev_oen_i ? dev_pin_i : pd_n_i;
    // an interrupt is a low level that the device itself drives
    assign irq_seen_o = !dev_oen_i && !dev_pin_i;
endmodule : psic_host_model
`default_nettype wire

// >>> testbench/phy_status_and_interrupt_control_tb.sv
// Purpose: self-checking bench for the status summary and interrupt control
// Assumes: avalon-mm master holds each request until waitrequest low
// Notes: integer model of control, enables and pending events
`timescale 1ns/100ps
`default_nettype none
module phy_status_and_interrupt_control_tb;
    import psic_pkg::*;
    logic clk_i, resetn_i, rd, wr, pd_n, pin_o, oen, pdreq, wt, pin_lvl, irq_seen;
    logic [7:0] adr, evt;
    logic [31:0] wd, rdat, q;
    logic [5:0] st;
    int failures, cmp_count, ctl, en, pend;
    psic_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .jabber_i(st[5]), .autoneg_done_i(st[4]), .loopback_i(st[3]),
        .full_duplex_i(st[2]), .speed_10_i(st[1]), .link_up_i(st[0]), .event_i(evt),
        .powerdown_or_irq_pin_i(pin_lvl), .powerdown_or_irq_pin_o(pin_o),
        .powerdown_or_irq_pin_oen_o(oen), .powerdown_req_o(pdreq));
    psic_host_model u_host (.dev_pin_i(pin_o), .dev_oen_i(oen), .pd_n_i(pd_n),
        .pin_lvl_o(pin_lvl), .irq_seen_o(irq_seen));
    // expected summary word and pin state
    function automatic logic [31:0] sum();
        return {24'h0, ctl[CTL_TEST_INTERRUPT_FORCE] || pend != 0, 1'b0, st[5] & st[1], st[4:0]};
    endfunction : sum
    function automatic logic [31:0] exp_irq();
        return {31'h0, ctl[CTL_OE] && (ctl[CTL_TEST_INTERRUPT_FORCE] || (ctl[CTL_GEN] && (pend & en) != 0))};
    endfunction : exp_irq
    // verdict and end of run
    task automatic tally_and_finish();
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [7:0] a, input bit w, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= {16'h0, d};
        // look at waitrequest mid-cycle, where it has settled, then take the answer at the next rising edge
        do begin
            @(negedge clk_i);
            n++;
        end while (wt !== 1'b0 && n < 20);
        if (n >= 20) failures++;
        @(posedge clk_i);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wctl(input int v);
        ctl = v;
        bus(IDX_INT_CTRL, 1, 16'(v));
        repeat (2) @(posedge clk_i);
    endtask : wctl
    task automatic pulse(input int i);
        @(posedge clk_i);
        evt <= 8'h01 << i;
        @(posedge clk_i);
        evt <= 8'h00;
        pend |= 1 << i;
        repeat (2) @(posedge clk_i);
    endtask : pulse
    // clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // watchdog
    initial begin
        #1000000;
        failures++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {resetn_i, rd, wr, adr, wd, evt, st} = '0;
        pd_n = 1'b1;
        {failures, cmp_count, ctl, en, pend} = '0;
        void'($urandom(33419));
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        bus(IDX_INT_CTRL, 0, 0);
        chk(q, 0);
        chk({31'h0, oen}, 1);
        for (int i = 0; i < 10; i++) begin
            st <= 6'($urandom);
            bus(IDX_SUMMARY, 0, 0);
            chk(q, sum());
            bus(IDX_SUMMARY, 0, 0);
            chk(q, sum());
        end
        bus(IDX_INT_CTRL, 1, 16'hfff8);
        bus(IDX_INT_CTRL, 0, 0);
        chk(q, 0);
        wctl(5);
        chk({31'h0, irq_seen}, exp_irq());
        bus(IDX_SUMMARY, 0, 0);
        chk(q, sum());
        repeat (5) @(posedge clk_i);
        chk({31'h0, irq_seen}, exp_irq());
        wctl(1);
        chk({31'h0, irq_seen}, exp_irq());
        en = $urandom & 255;
        bus(IDX_EVENT, 1, 16'(en));
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            chk({31'h0, irq_seen}, exp_irq());
        end
        bus(IDX_EVENT, 0, 0);
        chk(q, 32'(pend << 8 | en));
        pend = 0;
        wctl(3);
        for (int i = 0; i < 8; i++) begin
            pulse(i);
            chk({31'h0, irq_seen}, exp_irq());
            bus(IDX_EVENT, 0, 0);
            chk(q, 32'(pend << 8 | en));
            pend = 0;
            repeat (2) @(posedge clk_i);
            chk({31'h0, irq_seen}, exp_irq());
        end
        wctl(0);
        pd_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({31'h0, pdreq}, 1);
        pd_n <= 1'b1;
        bus(8'h20, 0, 0);
        chk(q, 0);
        tally_and_finish();
    end
endmodule : phy_status_and_interrupt_control_tb
`default_nettype wire
